// ===== design/sstc_pkg.sv
package sstc_pkg;
	// Command codes of the three word registers
	localparam logic [7:0]  CMD_TURN_ON_DELAY_TIME = 8'h60;
	localparam logic [7:0]  CMD_OUTPUT_RAMP_TIME   = 8'h61;
	localparam logic [7:0]  CMD_RAMP_TIMEOUT_LIMIT = 8'h62;
	// Linear-format field layout
	localparam int          EXP_MSB  = 15;
	localparam int          EXP_LSB  = 11;
	localparam int          MAN_MSB  = 10;
	localparam int          MAN_LSB  = 0;
	// Reset values: exponents as printed, mantissas zero
	localparam logic [15:0] RST_TURN_ON_DELAY_TIME = 16'hF800;
	localparam logic [15:0] RST_OUTPUT_RAMP_TIME   = 16'hF000;
	localparam logic [15:0] RST_RAMP_TIMEOUT_LIMIT = 16'hF800;
	// Times in quarter milliseconds
	localparam int          DELAY_MAX_QMS   = 510;
	localparam int          DELAY_STEP_QMS  = 2;
	localparam int          RAMP_MAX_QMS    = 127;
	localparam int          RAMP_STEP_QMS   = 1;
	localparam int          RAMP_FLOOR_QMS  = 2;
	localparam int          TMO_MAX_QMS     = 508;
	localparam int          TMO_STEP_QMS    = 2;
	// Timing
	localparam int          CLK_HZ          = 10_000_000;
	localparam int          QMS_US          = 250;
	localparam int          QMS_CYC         = (CLK_HZ / 1_000_000) * QMS_US;
	localparam int          INIT_DELAY_US   = 100;
	localparam int          INIT_DELAY_CYC  = (INIT_DELAY_US * CLK_HZ + 999_999) / 1_000_000;
	// Thresholds in eighths and twentieths of the target
	localparam int          TMO_NUM         = 7;
	localparam int          TMO_DEN_SH      = 3;
	localparam int          REACH_NUM       = 17;
	localparam int          REACH_DEN       = 20;
endpackage

// ===== design/sstc_lin_decode.sv
// Decodes a linear word to quarter-milliseconds and checks the grid.
module sstc_lin_decode (
	input  wire logic [15:0] word,
	input  wire logic [9:0]  max_qms,
	input  wire logic [1:0]  step_qms,
	output logic      [9:0]  qms,
	output logic             valid
);
	logic signed [4:0]  e;
	logic signed [10:0] m;
	logic        [31:0] v;
	logic               exact;
	always_comb begin
		e     = word[sstc_pkg::EXP_MSB:sstc_pkg::EXP_LSB];
		m     = word[sstc_pkg::MAN_MSB:sstc_pkg::MAN_LSB];
		v     = 32'h0000_0000;
		exact = 1'b1;
		// Value times four: mantissa shifted by exponent plus two
		if (m < 0) begin
			exact = 1'b0;
		end else if (e + 5'sd2 >= 0) begin
			v = 32'(unsigned'(m)) << (e + 5'sd2);
			if (e > 5'sd8)
				exact = (m == 11'sd0);
		end else begin
			v     = 32'(unsigned'(m)) >> (-(e + 5'sd2));
			exact = ((v << (-(e + 5'sd2))) == 32'(unsigned'(m)));
		end
		valid = exact && (v <= 32'(max_qms)) && (v % 32'(step_qms) == 32'h0000_0000);
		qms   = v[9:0];
	end
endmodule // sstc_lin_decode

// ===== design/sstc_top.sv
module sstc_top (
	input  wire logic        CLK,
	input  wire logic        RESET_N,
	input  wire logic        CE,
	input  wire logic        CMD_WR,
	input  wire logic        CMD_RD,
	input  wire logic [7:0]  CMD_CODE,
	input  wire logic [15:0] CMD_WDATA,
	input  wire logic        RESTORE,
	input  wire logic        START,
	input  wire logic [15:0] TARGET_VOUT,
	input  wire logic [15:0] VOUT_TELEMETRY,
	input  wire logic        STATUS_CLEAR,
	output logic      [15:0] CMD_RDATA,
	output logic             CMD_ACK,
	output logic             CMD_NACK,
	output logic             INVALID_DATA,
	output logic             RAMP_ACTIVE,
	output logic      [15:0] REF_STEP,
	output logic      [15:0] REF_LEVEL,
	output logic             UV_ENABLE,
	output logic             OUTPUT_GOOD,
	output logic             RAMP_TIMEOUT_FLAG,
	output logic             VOUT_SUMMARY,
	output logic             HOST_ALERT
);
	typedef enum logic [2:0] {
		S_IDLE  = 3'b000,
		S_INIT  = 3'b001,
		S_DELAY = 3'b011,
		S_RAMP  = 3'b010,
		S_ON    = 3'b110
	} sstc_state_e;

	logic [15:0] dly_q, dly_d, rmp_q, rmp_d, tmo_q, tmo_d;
	logic [9:0]  dly_qms, rmp_qms, tmo_qms;
	logic        dly_ok, rmp_ok, tmo_ok;
	logic [9:0]  dly_new_qms;
	logic        dly_new_ok;

	sstc_lin_decode u_dly (
		.word     (dly_q),
		.max_qms  (10'(sstc_pkg::DELAY_MAX_QMS)),
		.step_qms (2'(sstc_pkg::RAMP_STEP_QMS)),
		.qms      (dly_qms),
		.valid    (dly_ok)
	);
	sstc_lin_decode u_rmp (
		.word     (rmp_q),
		.max_qms  (10'(sstc_pkg::RAMP_MAX_QMS)),
		.step_qms (2'(sstc_pkg::RAMP_STEP_QMS)),
		.qms      (rmp_qms),
		.valid    (rmp_ok)
	);
	sstc_lin_decode u_tmo (
		.word     (tmo_q),
		.max_qms  (10'(sstc_pkg::TMO_MAX_QMS)),
		.step_qms (2'(sstc_pkg::TMO_STEP_QMS)),
		.qms      (tmo_qms),
		.valid    (tmo_ok)
	);
	// Shared checker for incoming words, steps chosen by command code
	logic [9:0] chk_max;
	logic [1:0] chk_step;
	always_comb begin
		if (CMD_CODE == sstc_pkg::CMD_TURN_ON_DELAY_TIME) begin
			chk_max  = 10'(sstc_pkg::DELAY_MAX_QMS);
			chk_step = 2'(sstc_pkg::DELAY_STEP_QMS);
		end else if (CMD_CODE == sstc_pkg::CMD_OUTPUT_RAMP_TIME) begin
			chk_max  = 10'(sstc_pkg::RAMP_MAX_QMS);
			chk_step = 2'(sstc_pkg::RAMP_STEP_QMS);
		end else begin
			chk_max  = 10'(sstc_pkg::TMO_MAX_QMS);
			chk_step = 2'(sstc_pkg::TMO_STEP_QMS);
		end
	end
	sstc_lin_decode u_chk (
		.word     (CMD_WDATA),
		.max_qms  (chk_max),
		.step_qms (chk_step),
		.qms      (dly_new_qms),
		.valid    (dly_new_ok)
	);

	function automatic logic is_mapped(input logic [7:0] c);
		return (c == sstc_pkg::CMD_TURN_ON_DELAY_TIME) || (c == sstc_pkg::CMD_OUTPUT_RAMP_TIME)
			|| (c == sstc_pkg::CMD_RAMP_TIMEOUT_LIMIT);
	endfunction

	// Snap a delay of quarter ms to nearest half-ms grid, clipped to range
	function automatic logic [15:0] snap_delay(input logic [9:0] q);
		logic [10:0] h;
		h = ({1'b0, q} + 11'h001) >> 1;
		if (h > 11'(sstc_pkg::DELAY_MAX_QMS / sstc_pkg::DELAY_STEP_QMS))
			h = 11'(sstc_pkg::DELAY_MAX_QMS / sstc_pkg::DELAY_STEP_QMS);
		return {5'b11111, h};
	endfunction

	// Register file and command answers
	logic [15:0] rdata_q, rdata_d;
	logic        ack_q, ack_d, nack_q, nack_d, inv_q, inv_d;
	logic        restore_s1_q, restore_s2_q, restore_s3_q;
	logic        restore_pulse;
	assign restore_pulse = restore_s2_q && !restore_s3_q;
	always_comb begin
		dly_d   = dly_q;
		rmp_d   = rmp_q;
		tmo_d   = tmo_q;
		rdata_d = rdata_q;
		ack_d   = 1'b0;
		nack_d  = 1'b0;
		inv_d   = inv_q && !STATUS_CLEAR;
		if (restore_pulse) begin
			dly_d = snap_delay(dly_qms);
		end
		if (CMD_WR) begin
			if (is_mapped(CMD_CODE) && dly_new_ok) begin
				ack_d = 1'b1;
				if (CMD_CODE == sstc_pkg::CMD_TURN_ON_DELAY_TIME)
					dly_d = CMD_WDATA;
				else if (CMD_CODE == sstc_pkg::CMD_OUTPUT_RAMP_TIME)
					rmp_d = CMD_WDATA;
				else
					tmo_d = CMD_WDATA;
			end else begin
				nack_d = 1'b1;
				inv_d  = 1'b1;
			end
		end else if (CMD_RD) begin
			if (CMD_CODE == sstc_pkg::CMD_TURN_ON_DELAY_TIME) begin
				rdata_d = dly_q;
				ack_d   = 1'b1;
			end else if (CMD_CODE == sstc_pkg::CMD_OUTPUT_RAMP_TIME) begin
				rdata_d = rmp_q;
				ack_d   = 1'b1;
			end else if (CMD_CODE == sstc_pkg::CMD_RAMP_TIMEOUT_LIMIT) begin
				rdata_d = tmo_q;
				ack_d   = 1'b1;
			end else begin
				rdata_d = 16'h0000;
				nack_d  = 1'b1;
			end
		end
	end
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			dly_q        <= sstc_pkg::RST_TURN_ON_DELAY_TIME;
			rmp_q        <= sstc_pkg::RST_OUTPUT_RAMP_TIME;
			tmo_q        <= sstc_pkg::RST_RAMP_TIMEOUT_LIMIT;
			rdata_q      <= 16'h0000;
			ack_q        <= 1'b0;
			nack_q       <= 1'b0;
			inv_q        <= 1'b0;
			restore_s1_q <= 1'b0;
			restore_s2_q <= 1'b0;
			restore_s3_q <= 1'b0;
		end else if (CE) begin
			dly_q        <= dly_d;
			rmp_q        <= rmp_d;
			tmo_q        <= tmo_d;
			rdata_q      <= rdata_d;
			ack_q        <= ack_d;
			nack_q       <= nack_d;
			inv_q        <= inv_d;
			restore_s1_q <= RESTORE;
			restore_s2_q <= restore_s1_q;
			restore_s3_q <= restore_s2_q;
		end
	end

	// Start-up sequencer
	sstc_state_e st_q, st_d;
	// Wide enough for the longest delay, 510 quarter ms of cycles
	logic [20:0] cnt_q, cnt_d;
	logic [10:0] tmo_cnt_q, tmo_cnt_d;
	logic [14:0] qtick_q, qtick_d;
	logic        tmo_run_q, tmo_run_d, tflag_q, tflag_d, uv_q, uv_d, good_q, good_d;
	logic [15:0] level_q, level_d, step_q, step_d;
	logic [9:0]  ramp_eff;
	logic        qtick;
	logic [18:0] thr_tmo, thr_reach;
	assign ramp_eff  = (rmp_qms < 10'(sstc_pkg::RAMP_FLOOR_QMS)) ?
		10'(sstc_pkg::RAMP_FLOOR_QMS) : rmp_qms;
	assign qtick     = (qtick_q == 15'(sstc_pkg::QMS_CYC - 1));
	assign thr_tmo   = 19'((32'(TARGET_VOUT) * sstc_pkg::TMO_NUM) >> sstc_pkg::TMO_DEN_SH);
	assign thr_reach = 19'((32'(TARGET_VOUT) * sstc_pkg::REACH_NUM) / sstc_pkg::REACH_DEN);

	always_comb begin
		st_d      = st_q;
		cnt_d     = cnt_q;
		qtick_d   = qtick ? 15'h0000 : qtick_q + 15'h0001;
		tmo_cnt_d = tmo_cnt_q;
		tmo_run_d = tmo_run_q;
		tflag_d   = tflag_q && !STATUS_CLEAR;
		uv_d      = uv_q;
		good_d    = good_q;
		level_d   = level_q;
		step_d    = step_q;
		case (st_q)
			S_IDLE: begin
				uv_d    = 1'b0;
				good_d  = 1'b0;
				level_d = 16'h0000;
				if (START) begin
					st_d  = S_INIT;
					cnt_d = 21'(sstc_pkg::INIT_DELAY_CYC);
				end
			end
			S_INIT: begin
				cnt_d = cnt_q - 21'h0_0001;
				if (cnt_q <= 21'h0_0001) begin
					st_d  = S_DELAY;
					cnt_d = 21'(32'(dly_qms) * sstc_pkg::QMS_CYC);
				end
			end
			S_DELAY: begin
				if (cnt_q != 21'h0_0000)
					cnt_d = cnt_q - 21'h0_0001;
				else begin
					st_d      = S_RAMP;
					cnt_d     = 21'(32'(ramp_eff) * sstc_pkg::QMS_CYC);
					// Slope per cycle from target over ramp length
					step_d    = 16'((32'(TARGET_VOUT) << 8) / (32'(ramp_eff) * sstc_pkg::QMS_CYC));
					tmo_cnt_d = 11'(tmo_qms);
					tmo_run_d = (tmo_qms != 10'h000);
				end
			end
			S_RAMP: begin
				cnt_d   = cnt_q - 21'h0_0001;
				level_d = (17'(level_q) + 17'(step_q) > 17'(TARGET_VOUT)) ? TARGET_VOUT
					: level_q + step_q;
				if (cnt_q <= 21'h0_0001) begin
					st_d    = S_ON;
					level_d = TARGET_VOUT;
					uv_d    = 1'b1;
				end
			end
			default: begin
				if (!START)
					st_d = S_IDLE;
			end
		endcase
		if (st_q == S_RAMP || st_q == S_ON) begin
			if (19'(VOUT_TELEMETRY) >= thr_reach) begin
				good_d    = 1'b1;
				tmo_run_d = 1'b0;
			end else if (tmo_run_q && qtick) begin
				tmo_cnt_d = tmo_cnt_q - 11'h001;
				if (tmo_cnt_q <= 11'h001) begin
					tmo_run_d = 1'b0;
					if (19'(VOUT_TELEMETRY) < thr_tmo)
						tflag_d = 1'b1;
				end
			end
		end
		if (!START) begin
			st_d      = S_IDLE;
			tmo_run_d = 1'b0;
		end
	end
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			st_q      <= S_IDLE;
			cnt_q     <= 21'h0_0000;
			qtick_q   <= 15'h0000;
			tmo_cnt_q <= 11'h000;
			tmo_run_q <= 1'b0;
			tflag_q   <= 1'b0;
			uv_q      <= 1'b0;
			good_q    <= 1'b0;
			level_q   <= 16'h0000;
			step_q    <= 16'h0000;
		end else if (CE) begin
			st_q      <= st_d;
			cnt_q     <= cnt_d;
			qtick_q   <= qtick_d;
			tmo_cnt_q <= tmo_cnt_d;
			tmo_run_q <= tmo_run_d;
			tflag_q   <= tflag_d;
			uv_q      <= uv_d;
			good_q    <= good_d;
			level_q   <= level_d;
			step_q    <= step_d;
		end
	end

	logic ramp_q, alert_q;
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ramp_q  <= 1'b0;
			alert_q <= 1'b0;
		end else if (CE) begin
			ramp_q  <= (st_d == S_RAMP);
			// Next values keep the alert in step with the flags it summarises
			alert_q <= tflag_d || inv_d;
		end
	end

	assign CMD_RDATA         = rdata_q;
	assign CMD_ACK           = ack_q;
	assign CMD_NACK          = nack_q;
	assign INVALID_DATA      = inv_q;
	assign RAMP_ACTIVE       = ramp_q;
	assign REF_STEP          = step_q;
	assign REF_LEVEL         = level_q;
	assign UV_ENABLE         = uv_q;
	assign OUTPUT_GOOD       = good_q;
	assign RAMP_TIMEOUT_FLAG = tflag_q;
	assign VOUT_SUMMARY      = tflag_q;
	assign HOST_ALERT        = alert_q;

	a_bad_write_flag: assert property (@(posedge CLK) disable iff (!RESET_N)
		CE && CMD_WR && !dly_new_ok |=> CMD_NACK && INVALID_DATA)
		else $error("invalid write not flagged");
	a_zero_tmo_off: assert property (@(posedge CLK) disable iff (!RESET_N)
		tmo_qms == 10'h000 && $stable(tmo_q) && !tflag_q |=> !tflag_q || $past(tmo_run_q))
		else $error("timeout fault with zero limit");
	a_uv_after_ramp: assert property (@(posedge CLK) disable iff (!RESET_N)
		$rose(UV_ENABLE) |-> $past(st_q) == S_RAMP)
		else $error("undervoltage enabled outside ramp end");
	a_init_min_delay: assert property (@(posedge CLK) disable iff (!RESET_N)
		st_q == S_IDLE && st_d == S_INIT && CE |=> st_q == S_INIT [*8])
		else $error("init delay too short");
	a_alert_follows: assert property (@(posedge CLK) disable iff (!RESET_N)
		RAMP_TIMEOUT_FLAG |-> HOST_ALERT && VOUT_SUMMARY)
		else $error("timeout flag without alert");
	a_ramp_floor: assert property (@(posedge CLK) disable iff (!RESET_N)
		ramp_eff >= 10'(sstc_pkg::RAMP_FLOOR_QMS))
		else $error("ramp below floor");
	a_good_stops_tmo: assert property (@(posedge CLK) disable iff (!RESET_N)
		CE && START && (st_q == S_RAMP) && 19'(VOUT_TELEMETRY) >= thr_reach |=> !tmo_run_q)
		else $error("timeout still running after output reached");
	a_level_capped: assert property (@(posedge CLK) disable iff (!RESET_N)
		st_q == S_ON |-> REF_LEVEL == TARGET_VOUT || $changed(TARGET_VOUT))
		else $error("reference not at target after ramp");
endmodule // sstc_top

// ===== verification/sstc_host.sv
module sstc_host (
	input  wire logic        clk,
	input  wire logic        cmd_ack,
	input  wire logic        cmd_nack,
	input  wire logic [15:0] cmd_rdata,
	output logic             cmd_wr,
	output logic             cmd_rd,
	output logic      [7:0]  cmd_code,
	output logic      [15:0] cmd_wdata
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		cmd_wr    = 1'b0;
		cmd_rd    = 1'b0;
		cmd_code  = 8'h00;
		cmd_wdata = 16'h0000;
	end

	// One word per request; the answer is sampled one edge after the request is taken
	task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data,
			output logic ack, output logic [15:0] rdata);
		@(posedge clk);
		cmd_wr    <= wr;
		cmd_rd    <= ~wr;
		cmd_code  <= code;
		cmd_wdata <= data;
		@(posedge clk);
		cmd_wr    <= 1'b0;
		cmd_rd    <= 1'b0;
		// Released lines show the inverse so stale data never looks live
		cmd_code  <= ~code;
		cmd_wdata <= ~data;
		@(posedge clk);
		ack   = cmd_ack;
		rdata = cmd_rdata;
		if (cmd_ack === cmd_nack) begin
			ack = 1'bx;
		end
	endtask
endmodule // sstc_host

// ===== verification/tb_soft_start_timing_config.sv
module tb_soft_start_timing_config;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int Q    = sstc_pkg::QMS_CYC;
	localparam int INIT = sstc_pkg::INIT_DELAY_CYC;
	logic        clk = 1'b0, reset_n = 1'b0, start = 1'b0, restore = 1'b0, status_clear = 1'b0;
	logic [15:0] target = 16'h4000, telem = 16'h0000;
	logic        cmd_wr, cmd_rd, cmd_ack, cmd_nack, inv, ramp, uv, good, flag, summ, alert, ack;
	logic [7:0]  cmd_code;
	logic [15:0] cmd_wdata, cmd_rdata, rd, level, step;
	int          fail_count = 0;
	int          comparisons = 0;
	logic [7:0]  t_code [13] = '{8'h60, 8'h60, 8'h60, 8'h60, 8'h61, 8'h61, 8'h61,
		8'h62, 8'h62, 8'h64, 8'h60, 8'h61, 8'h62};
	logic [15:0] t_data [13] = '{16'hF8FF, 16'hF900, 16'hF001, 16'hFFFF, 16'hF07F, 16'hF080,
		16'hE801, 16'hF8FE, 16'hF8FF, 16'h0001, 16'h0001, 16'hF000, 16'hF802};
	logic        t_ack  [13] = '{1, 0, 0, 0, 1, 0, 0, 1, 0, 0, 1, 1, 1};
	logic [15:0] shadow [3] = '{16'hF800, 16'hF000, 16'hF800};

	always #50 clk = ~clk;

	sstc_host host (.clk(clk), .cmd_ack(cmd_ack), .cmd_nack(cmd_nack), .cmd_rdata(cmd_rdata),
		.cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));

	sstc_top uut (.CLK(clk), .RESET_N(reset_n), .CE(1'b1), .CMD_WR(cmd_wr), .CMD_RD(cmd_rd),
		.CMD_CODE(cmd_code), .CMD_WDATA(cmd_wdata), .RESTORE(restore), .START(start),
		.TARGET_VOUT(target), .VOUT_TELEMETRY(telem), .STATUS_CLEAR(status_clear),
		.CMD_RDATA(cmd_rdata), .CMD_ACK(cmd_ack), .CMD_NACK(cmd_nack), .INVALID_DATA(inv),
		.RAMP_ACTIVE(ramp), .REF_STEP(step), .REF_LEVEL(level), .UV_ENABLE(uv), .OUTPUT_GOOD(good),
		.RAMP_TIMEOUT_FLAG(flag), .VOUT_SUMMARY(summ), .HOST_ALERT(alert));

	task automatic tally_and_finish();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_rng(input string what, input int lo, input int hi, input int got);
		comparisons++;
		if (got < lo || got > hi) begin
			fail_count++;
			$display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask

	task automatic wr(input logic [7:0] code, input logic [15:0] data, input logic exp_ack);
		host.xfer(1'b1, code, data, ack, rd);
		chk("write ack", {15'h0000, exp_ack}, {15'h0000, ack});
	endtask

	task automatic rd_chk(input logic [7:0] code, input logic [15:0] exp, input logic exp_ack);
		host.xfer(1'b0, code, 16'h0000, ack, rd);
		chk("read ack", {15'h0000, exp_ack}, {15'h0000, ack});
		chk("read data", exp, rd);
	endtask

	task automatic clear_status();
		status_clear <= 1'b1;
		@(posedge clk);
		status_clear <= 1'b0;
		@(posedge clk);
	endtask

	function automatic logic pick(input int which);
		case (which)
			0: return ramp;
			1: return !ramp;
			default: return flag;
		endcase
	endfunction

	// Bounded wait; n is the number of edges seen
	task automatic wait_for(input int which, input int lim, output int n);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (!pick(which) && n < lim);
	endtask

	task automatic start_run(input int dly_cyc, input int ramp_cyc);
		int n;
		start <= 1'b1;
		wait_for(0, 40_000, n);
		chk_rng("delay cycles", dly_cyc - 3, dly_cyc + 3, n);
		chk("uv in ramp", 16'h0000, {15'h0000, uv});
		wait_for(1, 40_000, n);
		chk_rng("ramp cycles", ramp_cyc - 3, ramp_cyc + 3, n);
		repeat (2) @(posedge clk);
		chk("uv after ramp", 16'h0001, {15'h0000, uv});
		chk("ref level", target, level);
		chk("ref step", 16'((32'(target) << 8) / ramp_cyc), step);
	endtask

	task automatic stop_run();
		start <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	initial begin
		int n;
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		for (int j = 0; j < 3; j++) begin
			rd_chk(8'h60 + 8'(j), shadow[j], 1'b1);
		end
		rd_chk(8'h63, 16'h0000, 1'b0);
		clear_status();
		for (int i = 0; i < 13; i++) begin
			wr(t_code[i], t_data[i], t_ack[i]);
			if (t_ack[i]) begin
				shadow[t_code[i][1:0]] = t_data[i];
			end
			if (t_code[i] != 8'h64) begin
				rd_chk(t_code[i], shadow[t_code[i][1:0]], 1'b1);
			end
			chk("invalid flag", {15'h0000, ~t_ack[i]}, {15'h0000, inv});
			clear_status();
		end
		restore <= 1'b1;
		repeat (4) @(posedge clk);
		restore <= 1'b0;
		repeat (4) @(posedge clk);
		rd_chk(8'h60, 16'hF802, 1'b1);
		// Output held low: 1 ms delay, floored ramp, 1 ms limit
		start_run(INIT + 4 * Q, 2 * Q);
		wait_for(2, 20_000, n);
		chk_rng("timeout cycles", Q - 10, 2 * Q + 10, n);
		chk("summary", 16'h0001, {15'h0000, summ});
		chk("alert", 16'h0001, {15'h0000, alert});
		stop_run();
		clear_status();
		chk("flag cleared", 16'h0000, {15'h0000, flag});
		wr(8'h60, 16'hF800, 1'b1);
		wr(8'h62, 16'hF800, 1'b1);
		start_run(INIT, 2 * Q);
		wait_for(2, 12_000, n);
		chk("flag disabled", 16'h0000, {15'h0000, flag});
		stop_run();
		wr(8'h62, 16'hF802, 1'b1);
		telem <= target;
		start_run(INIT, 2 * Q);
		chk("output good", 16'h0001, {15'h0000, good});
		wait_for(2, 12_000, n);
		chk("flag reached", 16'h0000, {15'h0000, flag});
		stop_run();
		tally_and_finish();
	end

	// Tests take about 56000 cycles
	initial begin
		#9_000_000;
		fail_count++;
		tally_and_finish();
	end
endmodule // tb_soft_start_timing_config
